// [verilog/ioa_consts.svh]
// Constants for the indexed offset addressing decoder.
// Assumes inclusion by bare name from the decoder; the package does not include it.
`ifndef IOA_CONSTS_SVH
`define IOA_CONSTS_SVH

// Highest fast-bank operand treated as a frame offset
`define IOA_OFS_LIMIT 8'h5F
// Upper nibble of the fast-bank window above the offset range
`define IOA_FAST_HI 4'hF
// Extension fuse value after reset
`define IOA_FUSE_RST 1'b0
// Opcode patterns, compared against the top bits of the word
`define IOA_ADD_PAT 6'h09
`define IOA_BSET_PAT 4'h8
`define IOA_FILL_PAT 7'h34
// Field positions
`define IOA_A_BIT 8
`define IOA_D_BIT 9
// Fill value
`define IOA_ONES 8'hFF

`endif

// [verilog/ioa_pkg.sv]
// Types shared by the indexed offset addressing decoder.
// Uses no constants from the header; only the decoder includes it.
package ioa_pkg;
	// One state per phase of the instruction cycle
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_DECODE,
		PH_READ,
		PH_PROC,
		PH_WRITE
	} ioa_phase_type;

	typedef enum logic [1:0] {
		K_NONE,
		K_ADD,
		K_BSET,
		K_FILL
	} ioa_kind_type;
endpackage

// [verilog/ioa_decode.sv]
// Decoder and executor for the indexed add, bit set and fill-ones instructions.
// Assumes one instruction word offered at a time, taken only while busy_o is low.
// What this block does
// - With the extension on, a fast-bank operand of 5Fh or less is an offset added to the stack_frame_pointer.
// - The extension_enable_fuse is caught once at the first clock after reset, and zero means plain addressing only.
// - Word 0010 01d0 kkkk kkkk in indexed mode adds the accumulator to the byte at pointer plus k.
// - The indexed add writes the accumulator when d is zero and the memory byte when d is one.
// - The indexed add updates negative, signed_wrap_bit, carry, nibble_carry_bit and zero.
// - Word 1000 bbb0 kkkk kkkk in indexed mode sets bit b of the byte at pointer plus k, flags kept.
// - Word 0110 1000 kkkk kkkk in indexed mode writes FFh to the byte at pointer plus k, flags kept.
// - The offset reading applies only when the bank select bit is zero; otherwise the bank_select_register is used.
// - With the extension off, every operand is a literal fast-bank or banked address.
`include "ioa_consts.svh"

module ioa_decode
	import ioa_pkg::*;
#(
	parameter int DEPTH = 4096
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Configuration
	input wire logic extension_enable_fuse_i,
	input wire logic [11:0] stack_frame_pointer_i,
	input wire logic [3:0] bank_select_register_i,
	// Instruction
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	// Accumulator and memory preload, idle only; memory readback address, any time
	input wire logic acc_ld_i,
	input wire logic [7:0] acc_ld_data_i,
	input wire logic ld_we_i,
	input wire logic [11:0] ld_addr_i,
	input wire logic [7:0] ld_data_i,
	input wire logic [11:0] rd_addr_i,
	// Status
	output logic busy_o,
	output logic done_o,
	output logic ext_enabled_o,
	output logic indexed_o,
	output logic [11:0] eff_addr_o,
	output logic [7:0] acc_o,
	output logic [7:0] rd_data_o,
	output logic flag_n_o,
	output logic flag_ov_o,
	output logic flag_c_o,
	output logic flag_dc_o,
	output logic flag_z_o
);

	function automatic ioa_kind_type decode_kind(input logic [15:0] w);
		if (w[15:10] == `IOA_ADD_PAT)
			return K_ADD;
		else if (w[15:12] == `IOA_BSET_PAT)
			return K_BSET;
		else if (w[15:9] == `IOA_FILL_PAT)
			return K_FILL;
		return K_NONE;
	endfunction

	function automatic logic is_indexed(input logic [15:0] w, input logic fuse);
		// Offset reading only with the fuse set and the bank bit clear
		return fuse && !w[`IOA_A_BIT] && (w[7:0] <= `IOA_OFS_LIMIT);
	endfunction

	function automatic logic [11:0] calc_addr(input logic [15:0] w, input logic fuse,
		input logic [11:0] fsr, input logic [3:0] bank_select_register);
		if (is_indexed(w, fuse))
			return 12'(fsr + {4'h0, w[7:0]});
		else if (w[`IOA_A_BIT])
			return {bank_select_register, w[7:0]};
		else if (w[7:0] <= `IOA_OFS_LIMIT)
			return {4'h0, w[7:0]};
		return {`IOA_FAST_HI, w[7:0]};
	endfunction

	logic [7:0] mem_r [DEPTH];
	ioa_phase_type state_r, state_nxt;
	ioa_kind_type kind_r, kind_nxt;
	logic [15:0] instr_r, instr_nxt;
	logic [11:0] addr_r, addr_nxt;
	logic idx_r, idx_nxt;
	logic [7:0] opnd_r, opnd_nxt;
	logic [7:0] res_r, res_nxt;
	logic [7:0] acc_r, acc_nxt;
	logic [7:0] rd_r;
	logic n_r, n_nxt, ov_r, ov_nxt, c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
	logic fuse_r, fuse_nxt, fuse_seen_r;
	logic done_r, done_nxt, busy_r;
	logic mem_we;
	logic [8:0] sum;
	logic [4:0] nib;

	always_comb begin
		sum = {1'b0, acc_r} + {1'b0, opnd_r};
		nib = {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]};
		state_nxt = state_r;
		kind_nxt = kind_r;
		instr_nxt = instr_r;
		addr_nxt = addr_r;
		idx_nxt = idx_r;
		opnd_nxt = opnd_r;
		res_nxt = res_r;
		acc_nxt = acc_r;
		{n_nxt, ov_nxt, c_nxt, dc_nxt, z_nxt} = {n_r, ov_r, c_r, dc_r, z_r};
		done_nxt = 1'b0;
		mem_we = 1'b0;
		// Fuse is caught once after reset so a mid-run change cannot remap operands
		fuse_nxt = fuse_seen_r ? fuse_r : extension_enable_fuse_i;
		case (state_r)
			PH_IDLE: begin
				if (acc_ld_i)
					acc_nxt = acc_ld_data_i;
				if (instr_valid_i) begin
					instr_nxt = instr_i;
					state_nxt = PH_DECODE;
				end
			end
			PH_DECODE: begin
				kind_nxt = decode_kind(instr_r);
				idx_nxt = is_indexed(instr_r, fuse_r);
				addr_nxt = calc_addr(instr_r, fuse_r, stack_frame_pointer_i,
					bank_select_register_i);
				state_nxt = PH_READ;
			end
			PH_READ: begin
				opnd_nxt = mem_r[addr_r];
				state_nxt = PH_PROC;
			end
			PH_PROC: begin
				case (kind_r)
					K_ADD: begin
						res_nxt = sum[7:0];
						n_nxt = sum[7];
						ov_nxt = (acc_r[7] == opnd_r[7]) && (sum[7] != acc_r[7]);
						c_nxt = sum[8];
						dc_nxt = nib[4];
						z_nxt = (sum[7:0] == 8'h00);
					end
					K_BSET: res_nxt = opnd_r | (8'h01 << instr_r[11:9]);
					K_FILL: res_nxt = `IOA_ONES;
					default: res_nxt = opnd_r;
				endcase
				state_nxt = PH_WRITE;
			end
			PH_WRITE: begin
				if (kind_r == K_ADD && !instr_r[`IOA_D_BIT])
					acc_nxt = res_r;
				else if (kind_r != K_NONE)
					mem_we = 1'b1;
				done_nxt = 1'b1;
				state_nxt = PH_IDLE;
			end
			default: state_nxt = PH_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_r <= PH_IDLE;
			kind_r <= K_NONE;
			instr_r <= 16'h0000;
			addr_r <= 12'h000;
			idx_r <= 1'b0;
			opnd_r <= 8'h00;
			res_r <= 8'h00;
			acc_r <= 8'h00;
			{n_r, ov_r, c_r, dc_r, z_r} <= 5'h00;
			fuse_r <= `IOA_FUSE_RST;
			fuse_seen_r <= 1'b0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			instr_r <= instr_nxt;
			addr_r <= addr_nxt;
			idx_r <= idx_nxt;
			opnd_r <= opnd_nxt;
			res_r <= res_nxt;
			acc_r <= acc_nxt;
			{n_r, ov_r, c_r, dc_r, z_r} <= {n_nxt, ov_nxt, c_nxt, dc_nxt, z_nxt};
			fuse_r <= fuse_nxt;
			fuse_seen_r <= 1'b1;
			done_r <= done_nxt;
			busy_r <= (state_nxt != PH_IDLE);
		end
	end

	// Data memory is not reset; preload is refused while an instruction runs
	always_ff @(posedge core_clk_i) begin
		if (mem_we)
			mem_r[addr_r] <= res_r;
		else if (ld_we_i && state_r == PH_IDLE)
			mem_r[ld_addr_i] <= ld_data_i;
		rd_r <= mem_r[rd_addr_i];
	end

	assign busy_o = busy_r;
	assign done_o = done_r;
	assign ext_enabled_o = fuse_r;
	assign indexed_o = idx_r;
	assign eff_addr_o = addr_r;
	assign acc_o = acc_r;
	assign rd_data_o = rd_r;
	assign {flag_n_o, flag_ov_o, flag_c_o, flag_dc_o, flag_z_o} = {n_r, ov_r, c_r, dc_r, z_r};

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_idx_addr;
		state_r == PH_DECODE && fuse_r && !instr_r[8] && instr_r[7:0] <= 8'h5F
			|=> idx_r && addr_r == 12'($past(stack_frame_pointer_i) + {4'h0, $past(instr_r[7:0])});
	endproperty
	a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

	property p_fuse_off;
		state_r == PH_DECODE && !fuse_r |=> !idx_r;
	endproperty
	a_fuse_off: assert property (p_fuse_off) else $error("indexed with fuse off");

	property p_add_kind;
		state_r == PH_DECODE && instr_r[15:10] == 6'h09 |=> kind_r == K_ADD;
	endproperty
	a_add_kind: assert property (p_add_kind) else $error("add not decoded");

	property p_add_acc;
		state_r == PH_WRITE && kind_r == K_ADD && !instr_r[9] |=> acc_r == $past(res_r) && done_r;
	endproperty
	a_add_acc: assert property (p_add_acc) else $error("add result not in acc");

	property p_add_mem;
		state_r == PH_WRITE && kind_r == K_ADD && instr_r[9] |-> mem_we ##1 $stable(acc_r);
	endproperty
	a_add_mem: assert property (p_add_mem) else $error("add result not in memory");

	property p_add_flags;
		state_r == PH_PROC && kind_r == K_ADD
			|=> z_r == (res_r == 8'h00) && n_r == res_r[7];
	endproperty
	a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

	property p_bset;
		state_r == PH_PROC && kind_r == K_BSET
			|=> res_r == ($past(opnd_r) | (8'h01 << $past(instr_r[11:9]))) && $stable(z_r)
				&& $stable(c_r);
	endproperty
	a_bset: assert property (p_bset) else $error("bit set wrong");

	property p_fill;
		state_r == PH_PROC && kind_r == K_FILL |=> res_r == 8'hFF && $stable(n_r);
	endproperty
	a_fill: assert property (p_fill) else $error("fill wrong");

	property p_bank;
		state_r == PH_DECODE && instr_r[8] |=> !idx_r && addr_r[11:8] == $past(bank_select_register_i);
	endproperty
	a_bank: assert property (p_bank) else $error("banked address wrong");

	property p_phases;
		state_r == PH_IDLE && instr_valid_i
			|=> state_r == PH_DECODE ##1 state_r == PH_READ ##1 state_r == PH_PROC
				##1 state_r == PH_WRITE ##1 done_r && !busy_r;
	endproperty
	a_phases: assert property (p_phases) else $error("phase order wrong");

	c_idx_add: cover property (state_r == PH_WRITE && kind_r == K_ADD && idx_r);
	c_idx_bset: cover property (state_r == PH_WRITE && kind_r == K_BSET && idx_r);
	c_idx_fill: cover property (state_r == PH_WRITE && kind_r == K_FILL && idx_r);
	c_banked: cover property (state_r == PH_WRITE && instr_r[8] && kind_r != K_NONE);

endmodule

// [verif/indexed_offset_addressing_decode_test.sv]
// Self-checking bench for the indexed offset addressing decoder.
// Assumes the design files are compiled first; the bench drives every port itself.
module indexed_offset_addressing_decode_test
	import ioa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [15:0] w;
		logic [7:0] m;
		logic [7:0] a;
		logic [11:0] ea;
		logic [7:0] em;
		logic [7:0] ra;
		logic ix;
	} ioa_row_type;

	// Frame pointer A00h and bank 3 throughout
	localparam ioa_row_type ROWS [7] = '{
		'{16'h242C, 8'h20, 8'h17, 12'hA2C, 8'h20, 8'h37, 1'b1},
		'{16'h262C, 8'h20, 8'h17, 12'hA2C, 8'h37, 8'h17, 1'b1},
		'{16'h8E0A, 8'h55, 8'h17, 12'hA0A, 8'hD5, 8'h17, 1'b1},
		'{16'h805F, 8'h54, 8'h17, 12'hA5F, 8'h55, 8'h17, 1'b1},
		'{16'h682C, 8'h00, 8'h17, 12'hA2C, 8'hFF, 8'h17, 1'b1},
		'{16'h2660, 8'h01, 8'h02, 12'hF60, 8'h03, 8'h02, 1'b0},
		'{16'h272C, 8'h10, 8'h01, 12'h32C, 8'h11, 8'h01, 1'b0}
	};

	logic core_clk_i, rst_n_i, extension_enable_fuse_i, instr_valid_i, acc_ld_i, ld_we_i;
	logic [11:0] stack_frame_pointer_i, ld_addr_i, rd_addr_i;
	logic [3:0] bank_select_register_i;
	logic [15:0] instr_i;
	logic [7:0] acc_ld_data_i, ld_data_i, acc_o, rd_data_o;
	logic busy_o, done_o, ext_enabled_o, indexed_o;
	logic flag_n_o, flag_ov_o, flag_c_o, flag_dc_o, flag_z_o;
	logic [11:0] eff_addr_o;
	int errors, total_checks;

	ioa_decode dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.extension_enable_fuse_i(extension_enable_fuse_i),
		.stack_frame_pointer_i(stack_frame_pointer_i),
		.bank_select_register_i(bank_select_register_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .acc_ld_i(acc_ld_i),
		.acc_ld_data_i(acc_ld_data_i), .ld_we_i(ld_we_i), .ld_addr_i(ld_addr_i),
		.ld_data_i(ld_data_i), .rd_addr_i(rd_addr_i), .busy_o(busy_o), .done_o(done_o),
		.ext_enabled_o(ext_enabled_o), .indexed_o(indexed_o), .eff_addr_o(eff_addr_o),
		.acc_o(acc_o), .rd_data_o(rd_data_o), .flag_n_o(flag_n_o), .flag_ov_o(flag_ov_o),
		.flag_c_o(flag_c_o), .flag_dc_o(flag_dc_o), .flag_z_o(flag_z_o));

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Strobes stay up until idle, so no signal is driven twice in one step
	task automatic idle();
		instr_valid_i = 1'b0;
		ld_we_i = 1'b0;
		acc_ld_i = 1'b0;
		@(negedge core_clk_i);
	endtask

	task automatic ld(input logic [11:0] a, input logic [7:0] d, input logic [7:0] acc);
		ld_we_i = 1'b1;
		ld_addr_i = a;
		ld_data_i = d;
		acc_ld_i = 1'b1;
		acc_ld_data_i = acc;
		@(negedge core_clk_i);
	endtask

	// Offer a word; while busy a fill of A00h stays offered and must be ignored
	task automatic run(input logic [15:0] w);
		int n;
		n = 0;
		instr_i = w;
		instr_valid_i = 1'b1;
		@(negedge core_clk_i);
		instr_i = 16'h6800;
		while (done_o !== 1'b1 && n < 12) begin
			@(negedge core_clk_i);
			n++;
		end
		// Four phase edges follow the taking edge before done is seen
		chk(16'(n), 16'h0004);
	endtask

	task automatic rst(input logic fuse);
		rst_n_i = 1'b0;
		extension_enable_fuse_i = fuse;
		repeat (16) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		repeat (2) @(negedge core_clk_i);
		chk({acc_o, busy_o, done_o, flag_n_o, flag_ov_o, flag_c_o, flag_dc_o, flag_z_o}, 0);
		chk(ext_enabled_o, fuse);
	endtask

	initial begin
		{rst_n_i, instr_valid_i, acc_ld_i, ld_we_i, instr_i, acc_ld_data_i, ld_data_i} = 0;
		{extension_enable_fuse_i, ld_addr_i, rd_addr_i} = 0;
		stack_frame_pointer_i = 12'hA00;
		bank_select_register_i = 4'h3;
		rst(1'b1);
		ld(12'hA00, 8'h00, 8'h00);
		for (int i = 0; i < 7; i++) begin
			ld(ROWS[i].ea, ROWS[i].m, ROWS[i].a);
			idle();
			run(ROWS[i].w);
			rd_addr_i = ROWS[i].ea;
			idle();
			chk(eff_addr_o, ROWS[i].ea);
			chk(indexed_o, ROWS[i].ix);
			chk(rd_data_o, ROWS[i].em);
			chk(acc_o, ROWS[i].ra);
		end
		for (int b = 0; b < 8; b++) begin
			ld(12'hA40 + 12'(b), 8'h00, 8'h00);
			idle();
			run({4'h8, 3'(b), 1'b0, 8'h40 + 8'(b)});
			rd_addr_i = 12'hA40 + 12'(b);
			idle();
			chk(rd_data_o, 8'h01 << b);
		end
		// Back to back: flags must survive the following fill and bit set
		ld(12'hA10, 8'h80, 8'h80);
		idle();
		run(16'h2410);
		chk({flag_n_o, flag_ov_o, flag_c_o, flag_dc_o, flag_z_o}, 5'b01101);
		chk(acc_o, 8'h00);
		run(16'h6811);
		chk({flag_n_o, flag_ov_o, flag_c_o, flag_dc_o, flag_z_o}, 5'b01101);
		// The word left offered by run must drop before a preload, or it is taken
		idle();
		ld(12'hA12, 8'h01, 8'h7F);
		idle();
		run(16'h2412);
		chk({flag_n_o, flag_ov_o, flag_c_o, flag_dc_o, flag_z_o}, 5'b11010);
		run(16'h8E12);
		chk({flag_n_o, flag_ov_o, flag_c_o, flag_dc_o, flag_z_o}, 5'b11010);
		rd_addr_i = 12'hA00;
		idle();
		chk(rd_data_o, 8'h00);
		rd_addr_i = 12'hA12;
		@(negedge core_clk_i);
		chk(rd_data_o, 8'h81);
		rd_addr_i = 12'hA11;
		@(negedge core_clk_i);
		chk(rd_data_o, 8'hFF);
		// Plain addressing; the fuse input moving later must not matter
		rst(1'b0);
		extension_enable_fuse_i = 1'b1;
		ld(12'h02C, 8'h05, 8'h01);
		idle();
		run(16'h262C);
		rd_addr_i = 12'h02C;
		idle();
		chk(ext_enabled_o, 1'b0);
		chk(eff_addr_o, 12'h02C);
		chk(indexed_o, 1'b0);
		chk(rd_data_o, 8'h06);
		stop_test();
	end

	initial begin
		#100000;
		errors++;
		stop_test();
	end
endmodule
